// [core/pir_router.sv]
// Priority interrupt router top: APB registers, routing, vectors and lines
`timescale 1ns/1ps
module pir_router (
  // Clock, reset and enable
  input  wire logic                              CLK_SYS,
  input  wire logic                              SYS_RST,
  input  wire logic                              CE,
  // APB slave
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [pir_pkg::PIR_ADDR_W-1:0]    PADDR,
  input  wire logic [pir_pkg::PIR_DATA_W-1:0]    PWDATA,
  output logic      [pir_pkg::PIR_DATA_W-1:0]    PRDATA,
  output logic                                   PREADY,
  output logic                                   PSLVERR,
  // Peripheral requests
  input  wire logic [pir_pkg::PIR_NUM_IN-1:0]    IRQ_REQ,
  // Fast interrupt line
  output logic                                   FAST_IRQ,
  output logic                                   FAST_VEC_VLD,
  output logic      [pir_pkg::PIR_IDX_W-1:0]     FAST_VEC,
  // Normal interrupt line
  output logic                                   NORM_IRQ,
  output logic                                   NORM_VEC_VLD,
  output logic      [pir_pkg::PIR_IDX_W-1:0]     NORM_VEC,
  // Event interrupt
  output logic                                   EVT_IRQ
);
  import pir_pkg::*;

  // Stored configuration
  logic [PIR_NUM_IN-1:0]                 pol;
  logic [PIR_NUM_IN-1:0]                 sw_req;
  logic [PIR_NUM_IN-1:0][PIR_PRIO_W-1:0] prio;
  logic [PIR_NUM_IN-1:0]                 tgt;
  logic [PIR_PRIO_W-1:0]                 thr_fast;
  logic [PIR_PRIO_W-1:0]                 thr_norm;
  logic [PIR_EVT_W-1:0]                  evt_stat;
  logic [PIR_EVT_W-1:0]                  evt_mask;

  // Registered results
  logic                                  fast_hit_q;
  logic                                  norm_hit_q;
  logic [PIR_IDX_W-1:0]                  fast_idx_q;
  logic [PIR_IDX_W-1:0]                  norm_idx_q;
  logic [PIR_PRIO_W-1:0]                 fast_lvl_q;
  logic [PIR_PRIO_W-1:0]                 norm_lvl_q;
  logic [PIR_DATA_W-1:0]                 rdata;

  // Combinational results
  logic [PIR_NUM_IN-1:0]                 pend;
  logic [PIR_NUM_IN-1:0]                 cand_fast;
  logic [PIR_NUM_IN-1:0]                 cand_norm;
  logic                                  fast_hit;
  logic                                  norm_hit;
  logic [PIR_IDX_W-1:0]                  fast_idx;
  logic [PIR_IDX_W-1:0]                  norm_idx;
  logic [PIR_PRIO_W-1:0]                 fast_lvl;
  logic [PIR_PRIO_W-1:0]                 norm_lvl;

  // Request conditioning
  pir_req_cond u_cond (
    .req_in (IRQ_REQ),
    .pol    (pol),
    .sw_req (sw_req),
    .pend   (pend)
  );

  // Routing of each pending request to one target
  assign cand_fast = pend & ~tgt;
  assign cand_norm = pend & tgt;

  // Selection per target, each against its own threshold
  pir_prio_sel u_sel_fast (
    .cand (cand_fast),
    .prio (prio),
    .thr  (thr_fast),
    .hit  (fast_hit),
    .idx  (fast_idx),
    .lvl  (fast_lvl)
  );

  pir_prio_sel u_sel_norm (
    .cand (cand_norm),
    .prio (prio),
    .thr  (thr_norm),
    .hit  (norm_hit),
    .idx  (norm_idx),
    .lvl  (norm_lvl)
  );

  // APB decode
  wire       acc_phase = PSEL & PENABLE & CE;
  wire       setup     = PSEL & ~PENABLE & CE;
  wire       a_raw_lo  = (PADDR == PIR_OFS_RAW_LO);
  wire       a_raw_hi  = (PADDR == PIR_OFS_RAW_HI);
  wire       a_pol_lo  = (PADDR == PIR_OFS_POL_LO);
  wire       a_pol_hi  = (PADDR == PIR_OFS_POL_HI);
  wire       a_swr_lo  = (PADDR == PIR_OFS_SWR_LO);
  wire       a_swr_hi  = (PADDR == PIR_OFS_SWR_HI);
  wire       a_thr_f   = (PADDR == PIR_OFS_THR_FAST);
  wire       a_thr_n   = (PADDR == PIR_OFS_THR_NORM);
  wire       a_vec_f   = (PADDR == PIR_OFS_VEC_FAST);
  wire       a_vec_n   = (PADDR == PIR_OFS_VEC_NORM);
  wire       a_stat    = (PADDR == PIR_OFS_EVT_STAT);
  wire       a_mask    = (PADDR == PIR_OFS_EVT_MASK);
  wire       a_cfg     = pir_cfg_hit(PADDR);
  wire [5:0] cfg_idx   = pir_cfg_idx(PADDR);

  wire       mapped    = a_raw_lo | a_raw_hi | a_pol_lo | a_pol_hi
                       | a_swr_lo | a_swr_hi | a_thr_f | a_thr_n
                       | a_vec_f | a_vec_n | a_stat | a_mask | a_cfg;

  // Writes land only at the completing edge of a mapped access
  wire       wr_en     = acc_phase & PWRITE & mapped;

  // Zero wait states while enabled; a frozen block stalls the bus
  assign PREADY  = CE;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA  = rdata;

  // Per-input configuration word as read back
  wire [PIR_DATA_W-1:0] cfg_word =
    (32'(prio[cfg_idx]) << PIR_CFG_PRIO_LSB) | (32'(tgt[cfg_idx]) << PIR_CFG_TGT_BIT);

  // Vector words
  wire [PIR_DATA_W-1:0] vec_f_word =
    (32'(fast_hit_q) << PIR_VEC_VLD_BIT) | (32'(fast_lvl_q) << PIR_VEC_LVL_LSB)
    | (32'(fast_idx_q) << PIR_VEC_IDX_LSB);
  wire [PIR_DATA_W-1:0] vec_n_word =
    (32'(norm_hit_q) << PIR_VEC_VLD_BIT) | (32'(norm_lvl_q) << PIR_VEC_LVL_LSB)
    | (32'(norm_idx_q) << PIR_VEC_IDX_LSB);

  // Read multiplexer; unmapped addresses read zero
  wire [PIR_DATA_W-1:0] next_rdata =
      a_raw_lo ? pend[31:0]
    : a_raw_hi ? 32'(pend[PIR_NUM_IN-1:32])
    : a_pol_lo ? pol[31:0]
    : a_pol_hi ? 32'(pol[PIR_NUM_IN-1:32])
    : a_swr_lo ? sw_req[31:0]
    : a_swr_hi ? 32'(sw_req[PIR_NUM_IN-1:32])
    : a_thr_f  ? 32'(thr_fast)
    : a_thr_n  ? 32'(thr_norm)
    : a_vec_f  ? vec_f_word
    : a_vec_n  ? vec_n_word
    : a_stat   ? 32'(evt_stat)
    : a_mask   ? 32'(evt_mask)
    : a_cfg    ? cfg_word
    : 32'h0000_0000;

  // Read data is captured in the setup cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata <= 32'h0000_0000;
    end else if (setup) begin
      rdata <= next_rdata;
    end
  end

  // Polarity and software request registers
  wire [PIR_NUM_IN-1:0] next_pol =
    {a_pol_hi ? PWDATA[PIR_HI_W-1:0] : pol[PIR_NUM_IN-1:32],
     a_pol_lo ? PWDATA : pol[31:0]};
  wire [PIR_NUM_IN-1:0] next_sw_req =
    {a_swr_hi ? PWDATA[PIR_HI_W-1:0] : sw_req[PIR_NUM_IN-1:32],
     a_swr_lo ? PWDATA : sw_req[31:0]};

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pol    <= PIR_RST_POL;
      sw_req <= PIR_RST_SWR;
    end else if (wr_en) begin
      pol    <= next_pol;
      sw_req <= next_sw_req;
    end
  end

  // Thresholds; software raises them to allow nesting
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      thr_fast <= PIR_RST_THR;
      thr_norm <= PIR_RST_THR;
    end else if (wr_en) begin
      if (a_thr_f) begin
        thr_fast <= PWDATA[PIR_PRIO_W-1:0];
      end
      if (a_thr_n) begin
        thr_norm <= PWDATA[PIR_PRIO_W-1:0];
      end
    end
  end

  // Per-input priority and target
  genvar g;
  generate
    for (g = 0; g < PIR_NUM_IN; g++) begin : g_cfg
      wire sel = wr_en & a_cfg & (cfg_idx == 6'(g));
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          prio[g] <= PIR_RST_PRIO;
          tgt[g]  <= PIR_RST_TGT;
        end else if (sel) begin
          prio[g] <= PWDATA[PIR_CFG_PRIO_LSB +: PIR_PRIO_W];
          tgt[g]  <= PWDATA[PIR_CFG_TGT_BIT];
        end
      end
    end
  endgenerate

  // Lines and vectors follow the selection one edge later
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fast_hit_q <= 1'b0;
      norm_hit_q <= 1'b0;
      fast_idx_q <= '0;
      norm_idx_q <= '0;
      fast_lvl_q <= '0;
      norm_lvl_q <= '0;
    end else if (CE) begin
      fast_hit_q <= fast_hit;
      norm_hit_q <= norm_hit;
      fast_idx_q <= fast_idx;
      norm_idx_q <= norm_idx;
      fast_lvl_q <= fast_lvl;
      norm_lvl_q <= norm_lvl;
    end
  end

  assign FAST_IRQ     = fast_hit_q;
  assign NORM_IRQ     = norm_hit_q;
  assign FAST_VEC_VLD = fast_hit_q;
  assign NORM_VEC_VLD = norm_hit_q;
  assign FAST_VEC     = fast_idx_q;
  assign NORM_VEC     = norm_idx_q;

  // Line assertion events; a set in the clearing cycle wins
  wire [PIR_EVT_W-1:0] evt_set = {norm_hit & ~norm_hit_q, fast_hit & ~fast_hit_q};
  wire [PIR_EVT_W-1:0] evt_clr = (wr_en & a_stat) ? PWDATA[PIR_EVT_W-1:0] : '0;
  wire [PIR_EVT_W-1:0] next_evt_stat = (evt_stat & ~evt_clr) | evt_set;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      evt_stat <= PIR_RST_EVT;
      evt_mask <= PIR_RST_EVT;
    end else if (CE) begin
      evt_stat <= next_evt_stat;
      if (wr_en && a_mask) begin
        evt_mask <= PWDATA[PIR_EVT_W-1:0];
      end
    end
  end

  assign EVT_IRQ = |(evt_stat & evt_mask);

endmodule

// [core/pir_pkg.sv]
// Constants, register map and field layout of the priority interrupt router
// Overview of operation
// - Each of the 56 request inputs is level-active and its polarity bit picks the active level.
// - Each input has a software request bit that raises its interrupt without the peripheral.
// - Software can read every input's state after polarity and before priority masking.
// - Each input has a target bit: 0 routes it to the fast line and 1 to the normal line.
// - Masking is per target: a request's priority is compared with its own target's threshold.
// - A request with priority 0 is masked and never interrupts either target.
// - Software sets each request's priority from 1, lowest urgency, to 15, highest urgency.
// - A vector register names the pending request chosen for service on each target.
// - Software may raise a target's threshold in a handler so only higher levels nest in.
// - All logic runs synchronously on the router branch clock.
package pir_pkg;

  localparam int PIR_NUM_IN  = 56;
  localparam int PIR_PRIO_W  = 4;
  localparam int PIR_IDX_W   = 6;
  localparam int PIR_ADDR_W  = 12;
  localparam int PIR_DATA_W  = 32;
  localparam int PIR_HI_W    = PIR_NUM_IN - 32;

  // Register byte offsets
  localparam logic [11:0] PIR_OFS_RAW_LO   = 12'h000;
  localparam logic [11:0] PIR_OFS_RAW_HI   = 12'h004;
  localparam logic [11:0] PIR_OFS_POL_LO   = 12'h008;
  localparam logic [11:0] PIR_OFS_POL_HI   = 12'h00C;
  localparam logic [11:0] PIR_OFS_SWR_LO   = 12'h010;
  localparam logic [11:0] PIR_OFS_SWR_HI   = 12'h014;
  localparam logic [11:0] PIR_OFS_THR_FAST = 12'h018;
  localparam logic [11:0] PIR_OFS_THR_NORM = 12'h01C;
  localparam logic [11:0] PIR_OFS_VEC_FAST = 12'h020;
  localparam logic [11:0] PIR_OFS_VEC_NORM = 12'h024;
  localparam logic [11:0] PIR_OFS_EVT_STAT = 12'h028;
  localparam logic [11:0] PIR_OFS_EVT_MASK = 12'h02C;
  localparam logic [11:0] PIR_OFS_CFG_BASE = 12'h100;

  // Field positions
  localparam int PIR_CFG_PRIO_LSB = 0;
  localparam int PIR_CFG_TGT_BIT  = 8;
  localparam int PIR_VEC_IDX_LSB  = 0;
  localparam int PIR_VEC_LVL_LSB  = 8;
  localparam int PIR_VEC_VLD_BIT  = 31;
  localparam int PIR_EVT_FAST_BIT = 0;
  localparam int PIR_EVT_NORM_BIT = 1;
  localparam int PIR_EVT_W        = 2;

  // Target encodings and reset values
  localparam logic              PIR_TGT_FAST   = 1'b0;
  localparam logic              PIR_TGT_NORM   = 1'b1;
  localparam logic [3:0]        PIR_RST_PRIO   = 4'h0;
  localparam logic [3:0]        PIR_RST_THR    = 4'h0;
  localparam logic              PIR_RST_TGT    = 1'b1;
  localparam logic [55:0]       PIR_RST_POL    = 56'h00_0000_0000_0000;
  localparam logic [55:0]       PIR_RST_SWR    = 56'h00_0000_0000_0000;
  localparam logic [1:0]        PIR_RST_EVT    = 2'h0;

  // Per-input configuration word: hit flag and input index
  function automatic logic pir_cfg_hit(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - PIR_OFS_CFG_BASE;
    return (addr >= PIR_OFS_CFG_BASE) && (rel[1:0] == 2'h0)
           && (rel[11:2] < 10'(PIR_NUM_IN));
  endfunction

  function automatic logic [5:0] pir_cfg_idx(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - PIR_OFS_CFG_BASE;
    return rel[7:2];
  endfunction

endpackage

// [core/pir_req_cond.sv]
// Request conditioning: polarity and software requests per input
`timescale 1ns/1ps
module pir_req_cond (
  // Peripheral side
  input  wire logic [pir_pkg::PIR_NUM_IN-1:0] req_in,
  // Software controls
  input  wire logic [pir_pkg::PIR_NUM_IN-1:0] pol,
  input  wire logic [pir_pkg::PIR_NUM_IN-1:0] sw_req,
  // Conditioned requests
  output logic      [pir_pkg::PIR_NUM_IN-1:0] pend
);
  import pir_pkg::*;

  genvar g;
  generate
    for (g = 0; g < PIR_NUM_IN; g++) begin : g_in
      // Polarity bit set means the low level requests
      assign pend[g] = (req_in[g] ^ pol[g]) | sw_req[g];
    end
  endgenerate

endmodule

// [core/pir_prio_sel.sv]
// Per-target selection of the most urgent request above a threshold
`timescale 1ns/1ps
module pir_prio_sel (
  // Candidates routed to this target
  input  wire logic [pir_pkg::PIR_NUM_IN-1:0]                        cand,
  input  wire logic [pir_pkg::PIR_NUM_IN-1:0][pir_pkg::PIR_PRIO_W-1:0] prio,
  input  wire logic [pir_pkg::PIR_PRIO_W-1:0]                        thr,
  // Selection result
  output logic                                                       hit,
  output logic      [pir_pkg::PIR_IDX_W-1:0]                         idx,
  output logic      [pir_pkg::PIR_PRIO_W-1:0]                        lvl
);
  import pir_pkg::*;

  // Strict compare keeps the lowest index on equal levels; a level must
  // exceed the threshold, so level 0 never wins
  always_comb begin
    hit = 1'b0;
    idx = '0;
    lvl = thr;
    for (int i = 0; i < PIR_NUM_IN; i++) begin
      if (cand[i] && (prio[i] > lvl)) begin
        hit = 1'b1;
        idx = PIR_IDX_W'(i);
        lvl = prio[i];
      end
    end
  end

endmodule

// [tb/pir_core_model.sv]
// Processor core model: counts entries taken on the fast and normal lines
`timescale 1ns/1ps
module pir_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Interrupt lines from the router
  input  wire logic       fast,
  input  wire logic       norm,
  // Entry counts
  output logic      [7:0] fast_cnt,
  output logic      [7:0] norm_cnt
);
  logic fast_q;
  logic norm_q;

  // A level line is entered once per rise
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_q   <= 1'b0;
      norm_q   <= 1'b0;
      fast_cnt <= 8'h00;
      norm_cnt <= 8'h00;
    end else begin
      fast_q <= fast;
      norm_q <= norm;
      if (fast && !fast_q) fast_cnt <= fast_cnt + 8'h01;
      if (norm && !norm_q) norm_cnt <= norm_cnt + 8'h01;
    end
  end
endmodule

// [tb/pir_router_assertions.sv]
// Concurrent checks on the router's ports
`timescale 1ns/1ps
module pir_router_assertions (
  // Clock, reset and enable
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  input wire logic        CE,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Requests and lines
  input wire logic [55:0] IRQ_REQ,
  input wire logic        FAST_IRQ,
  input wire logic        FAST_VEC_VLD,
  input wire logic [5:0]  FAST_VEC,
  input wire logic        NORM_IRQ,
  input wire logic        NORM_VEC_VLD,
  input wire logic [5:0]  NORM_VEC,
  input wire logic        EVT_IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  chk_fast_vld_line: assert property (FAST_VEC_VLD == FAST_IRQ)
    else $error("fast vector valid differs from line");
  chk_norm_vld_line: assert property (NORM_VEC_VLD == NORM_IRQ)
    else $error("normal vector valid differs from line");
  chk_ready_ce: assert property (PREADY == CE)
    else $error("ready does not follow enable");
  chk_reset_quiet: assert property (disable iff (1'b0)
    SYS_RST |=> !FAST_IRQ && !NORM_IRQ && !EVT_IRQ)
    else $error("line high right after reset");
  chk_frozen_ce: assert property (!CE && !SYS_RST |=> $stable(FAST_IRQ)
    && $stable(NORM_IRQ) && $stable(FAST_VEC) && $stable(NORM_VEC) && $stable(EVT_IRQ))
    else $error("state moved while enable low");
  chk_vec_settled: assert property ((CE && !(PSEL && PENABLE && PWRITE))
    ##1 (CE && $stable(IRQ_REQ)) |=> $stable(FAST_VEC) && $stable(NORM_VEC)
    && $stable(FAST_IRQ) && $stable(NORM_IRQ))
    else $error("outputs changed with no cause");
  chk_unmapped_read: assert property ((PSEL && !PENABLE && !PWRITE && CE
    && PADDR == 12'h030) ##1 PENABLE |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped read not refused");
  chk_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access phase");
endmodule

bind pir_router pir_router_assertions u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ_REQ(IRQ_REQ), .FAST_IRQ(FAST_IRQ),
  .FAST_VEC_VLD(FAST_VEC_VLD), .FAST_VEC(FAST_VEC), .NORM_IRQ(NORM_IRQ),
  .NORM_VEC_VLD(NORM_VEC_VLD), .NORM_VEC(NORM_VEC), .EVT_IRQ(EVT_IRQ));

// [tb/tb_top.sv]
// Self-checking bench for the priority interrupt router
`timescale 1ns/1ps
module tb_top;
  import pir_pkg::*;
  localparam logic [11:0] C5  = PIR_OFS_CFG_BASE + 12'h014;
  localparam logic [11:0] C35 = PIR_OFS_CFG_BASE + 12'h08C;
  localparam logic [11:0] C40 = PIR_OFS_CFG_BASE + 12'h0A0;
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [55:0] irq;
  logic        f_irq, f_vld, n_irq, n_vld, evt;
  logic [5:0]  f_vec, n_vec;
  logic [7:0]  f_cnt, n_cnt;
  int          err_count, n_tests;

  pir_router dut (.CLK_SYS(clk), .SYS_RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ_REQ(irq), .FAST_IRQ(f_irq), .FAST_VEC_VLD(f_vld),
    .FAST_VEC(f_vec), .NORM_IRQ(n_irq), .NORM_VEC_VLD(n_vld), .NORM_VEC(n_vec),
    .EVT_IRQ(evt));
  pir_core_model core (.clk(clk), .rst(rst), .fast(f_irq), .norm(n_irq),
    .fast_cnt(f_cnt), .norm_cnt(n_cnt));

  task automatic report_and_stop;
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic chl(input logic f, input logic n);
    repeat (2) @(posedge clk);
    #1;
    chk(f_irq, f);
    chk(n_irq, n);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #2000000;
    err_count++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    irq = '0;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    irq <= '1;
    chl(1'b0, 1'b0);
    rdc(PIR_OFS_RAW_LO, 32'hFFFFFFFF);
    rdc(PIR_OFS_RAW_HI, 32'h00FFFFFF);
    wr(PIR_OFS_POL_LO, 32'hFFFFFFFF);
    wr(PIR_OFS_POL_HI, 32'hFFFFFFFF);
    rdc(PIR_OFS_RAW_LO, 32'h0);
    irq <= '0;
    rdc(PIR_OFS_RAW_HI, 32'h00FFFFFF);
    wr(PIR_OFS_POL_LO, 32'h0);
    wr(PIR_OFS_POL_HI, 32'h0);
    // Software request on input 35, routed to the normal line
    wr(PIR_OFS_SWR_HI, 32'h8);
    rdc(PIR_OFS_RAW_HI, 32'h8);
    rdc(C35, 32'h100);
    wr(C35, 32'h105);
    chl(1'b0, 1'b1);
    chk(n_vec, 6'h23);
    chk(n_vld, 1'b1);
    rdc(PIR_OFS_VEC_NORM, 32'h80000523);
    wr(PIR_OFS_THR_NORM, 32'h5);
    chl(1'b0, 1'b0);
    wr(PIR_OFS_THR_NORM, 32'h4);
    wr(PIR_OFS_THR_FAST, 32'hFFFFFFFF);
    chl(1'b0, 1'b1);
    rdc(PIR_OFS_THR_FAST, 32'hF);
    wr(PIR_OFS_THR_FAST, 32'h0);
    wr(PIR_OFS_THR_NORM, 32'h0);
    for (int l = 0; l < 16; l++) begin
      wr(C35, 32'h100 | 32'(l));
      chl(1'b0, l != 0);
      if (l != 0) rdc(PIR_OFS_VEC_NORM, 32'h80000023 | 32'(l << 8));
    end
    wr(PIR_OFS_SWR_HI, 32'h0);
    chl(1'b0, 1'b0);
    // Fast line: tie, priority order and nesting
    wr(C5, 32'h003);
    wr(C40, 32'h003);
    irq <= 56'h00_0100_0000_0020;
    @(posedge clk);
    #1;
    chk(f_irq, 1'b1);
    chk(f_vec, 6'h05);
    wr(C40, 32'h009);
    chl(1'b1, 1'b0);
    chk(f_vec, 6'h28);
    chk(f_vld, 1'b1);
    wr(PIR_OFS_THR_FAST, 32'h9);
    chl(1'b0, 1'b0);
    wr(C40, 32'h00A);
    chl(1'b1, 1'b0);
    rdc(PIR_OFS_VEC_FAST, 32'h80000A28);
    // Events: both lines have risen by now, then clear, mask, raise
    rdc(PIR_OFS_EVT_STAT, 32'h3);
    wr(PIR_OFS_EVT_STAT, 32'h3);
    rdc(PIR_OFS_EVT_STAT, 32'h0);
    wr(PIR_OFS_EVT_MASK, 32'h1);
    wr(PIR_OFS_THR_FAST, 32'hF);
    chl(1'b0, 1'b0);
    chk(evt, 1'b0);
    wr(PIR_OFS_THR_FAST, 32'h0);
    chl(1'b1, 1'b0);
    chk(evt, 1'b1);
    rdc(PIR_OFS_EVT_STAT, 32'h1);
    wr(PIR_OFS_EVT_MASK, 32'h2);
    chl(1'b1, 1'b0);
    chk(evt, 1'b0);
    wr(PIR_OFS_EVT_STAT, 32'h1);
    rdc(PIR_OFS_EVT_STAT, 32'h0);
    // Unmapped places
    wr(12'h030, 32'hFFFFFFFF);
    rdc(12'h030, 32'h0);
    chk(se, 1'b1);
    rdc(PIR_OFS_CFG_BASE + 12'h0E0, 32'h0);
    chk(se, 1'b1);
    // Clock enable low freezes the lines
    ce <= 1'b0;
    irq <= '0;
    repeat (4) @(posedge clk);
    #1;
    chk(f_irq, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    chl(1'b0, 1'b0);
    chk(f_cnt, 8'h03);
    chk(n_cnt, 8'h03);
    report_and_stop;
  end
endmodule
